// ---- design/tcr_top.sv ----
// conversion control, scratchpad bytes and read-slot answer
`timescale 1ns/1ps
module tcr_top #(
    parameter int CONV_CYCLES = tcr_pkg::CONV_CYCLES_12
) (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        cmd_valid,
    input  wire logic [7:0]  cmd_byte,
    input  wire logic        ext_powered,
    input  wire logic [11:0] sensor_code,
    input  wire logic        slot_read,
    input  wire logic        slot_end,
    input  wire logic        dq_in,
    input  wire logic        scratch_wr,
    input  wire logic [1:0]  scratch_idx,
    input  wire logic [7:0]  scratch_wdata,
    input  wire logic        nv_store,
    input  wire logic        nv_recall,
    output logic             dq_out,
    output logic             dq_oe,
    output logic [15:0]      temperature_result,
    output logic [7:0]       limit_hi,
    output logic [7:0]       limit_lo,
    output logic [7:0]       config_byte,
    output logic             conv_busy,
    output logic             conv_done
);
    ////////////////////////////////////////////////////////////////////
    // elaboration checks
    generate
        if (CONV_CYCLES < 8 || CONV_CYCLES >= (1 << tcr_pkg::CNT_W)) begin
            $error("CONV_CYCLES out of range");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // identity code, declared here but read by no logic in the project;
    // the value is arbitrary and names no real part
    localparam logic [63:0] DEVICE_CODE = 64'h0000_5EED_0000_00A5;

    ////////////////////////////////////////////////////////////////////
    // state and registers
    tcr_pkg::tcr_state_type state_r;
    tcr_pkg::tcr_state_type state_nxt;
    logic [tcr_pkg::CNT_W-1:0] cnt_r;
    logic [tcr_pkg::CNT_W-1:0] cnt_nxt;
    logic [15:0] result_r;
    logic [7:0]  hi_r;
    logic [7:0]  lo_r;
    logic [7:0]  cfg_r;
    logic [7:0]  nv_hi_r;
    logic [7:0]  nv_lo_r;
    logic [7:0]  nv_cfg_r;
    logic        done_r;
    logic        oe_r;
    logic        busy_r;

    tcr_fmt_if fmt_bus ();

    tcr_format i_tcr_format (
        .f (fmt_bus.fmt)
    );

    ////////////////////////////////////////////////////////////////////
    // decode
    logic [1:0]                res_sel;
    logic                      start_conv;
    logic                      conv_last;
    logic [tcr_pkg::CNT_W-1:0] conv_len;
    logic                      answer_zero;

    assign res_sel = cfg_r[tcr_pkg::CFG_RES_LSB +: tcr_pkg::CFG_RES_W];
    // coarser resolutions halve the conversion time per dropped bit
    assign conv_len = tcr_pkg::CNT_W'(CONV_CYCLES)
                      >> (3'd3 - {1'b0, res_sel});
    // a start command while converting is ignored
    assign start_conv = cmd_valid && (cmd_byte == tcr_pkg::CMD_CONVERT)
                        && (state_r == tcr_pkg::TCR_IDLE);
    assign conv_last = (state_r == tcr_pkg::TCR_CONV) && (cnt_r == '0);
    // only a powered device may signal busy; parasite mode stays released
    assign answer_zero = ext_powered
                         && (state_r == tcr_pkg::TCR_CONV);

    assign fmt_bus.sample = sensor_code;
    assign fmt_bus.res    = res_sel;

    ////////////////////////////////////////////////////////////////////
    // conversion sequencer
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        case (state_r)
            tcr_pkg::TCR_IDLE: begin
                if (start_conv) begin
                    state_nxt = tcr_pkg::TCR_CONV;
                    cnt_nxt   = conv_len - 1'b1;
                end
            end
            tcr_pkg::TCR_CONV: begin
                if (cnt_r == '0) begin
                    state_nxt = tcr_pkg::TCR_IDLE;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            default: begin
                state_nxt = tcr_pkg::TCR_IDLE;
            end
        endcase
    end

    // power-up puts the sequencer idle; busy is taken from the next
    // state so the output leaves a flop with no decode behind it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= tcr_pkg::TCR_IDLE;
            cnt_r   <= '0;
            busy_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            busy_r  <= (state_nxt == tcr_pkg::TCR_CONV);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // result register and completion pulse
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            result_r <= tcr_pkg::RESULT_RESET;
            done_r   <= 1'b0;
        end else begin
            done_r <= conv_last;
            if (conv_last) begin
                result_r <= fmt_bus.result;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // scratchpad bytes; writes during a conversion are still taken,
    // the new resolution sets the length from the next start but already masks the running result
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hi_r  <= tcr_pkg::LIMIT_HI_RESET;
            lo_r  <= tcr_pkg::LIMIT_LO_RESET;
            cfg_r <= tcr_pkg::CFG_RESET;
        end else if (nv_recall) begin
            hi_r  <= nv_hi_r;
            lo_r  <= nv_lo_r;
            cfg_r <= nv_cfg_r;
        end else if (scratch_wr) begin
            if (scratch_idx == tcr_pkg::IDX_LIMIT_HI) begin
                hi_r <= scratch_wdata;
            end
            if (scratch_idx == tcr_pkg::IDX_LIMIT_LO) begin
                lo_r <= scratch_wdata;
            end
            if (scratch_idx == tcr_pkg::IDX_CONFIG) begin
                cfg_r <= scratch_wdata;
            end
        end
    end

    // stands in for the nonvolatile cells: no reset, so power loss
    // (resetn) leaves them intact; only a store changes them
    always_ff @(posedge clk) begin
        if (nv_store) begin
            nv_hi_r  <= hi_r;
            nv_lo_r  <= lo_r;
            nv_cfg_r <= cfg_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read-slot answer: open drain, pulls low only to send a zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            oe_r <= 1'b0;
        end else if (slot_read) begin
            oe_r <= answer_zero;
        end else if (slot_end) begin
            oe_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs
    assign dq_out             = 1'b0;
    assign dq_oe              = oe_r;
    assign temperature_result = result_r;
    assign limit_hi           = hi_r;
    assign limit_lo           = lo_r;
    assign config_byte        = cfg_r;
    assign conv_busy          = busy_r;
    assign conv_done          = done_r;

    ////////////////////////////////////////////////////////////////////
    // checks: conversion control
    a_idle_no_start: assert property (@(posedge clk)
        disable iff (!resetn)
        (state_r == tcr_pkg::TCR_IDLE && !(cmd_valid
         && cmd_byte == tcr_pkg::CMD_CONVERT)) |=> !conv_busy)
        else $error("conversion started without start command");

    a_start_enters: assert property (@(posedge clk)
        disable iff (!resetn) start_conv |=> conv_busy)
        else $error("start command did not begin conversion");

    a_busy_counts: assert property (@(posedge clk)
        disable iff (!resetn)
        (state_r == tcr_pkg::TCR_CONV && cnt_r != '0)
        |=> (conv_busy && cnt_r == $past(cnt_r) - 1'b1))
        else $error("running conversion restarted or stalled");

    a_conv_returns: assert property (@(posedge clk)
        disable iff (!resetn)
        conv_last |=> (!conv_busy && conv_done
                       && temperature_result == $past(fmt_bus.result)))
        else $error("conversion end did not store and go idle");

    a_done_single: assert property (@(posedge clk)
        disable iff (!resetn) conv_done |=> !conv_done)
        else $error("completion pulse longer than one cycle");

    a_result_hold: assert property (@(posedge clk)
        disable iff (!resetn) !conv_last |=> $stable(temperature_result))
        else $error("result changed outside a conversion end");

    a_conv_length: assert property (@(posedge clk)
        disable iff (!resetn)
        (start_conv && res_sel == tcr_pkg::RES_12BIT) |=> conv_busy [*8])
        else $error("12-bit conversion ended too early");

    ////////////////////////////////////////////////////////////////////
    // checks: result format
    a_sign_extend: assert property (@(posedge clk)
        disable iff (!resetn)
        conv_done |-> (temperature_result[15:11]
                       == {5{temperature_result[11]}}))
        else $error("result sign not extended");

    a_whole_degrees: assert property (@(posedge clk)
        disable iff (!resetn)
        conv_done |-> (temperature_result[11:4] == $past(sensor_code[11:4])))
        else $error("sign or integer bits differ from the sample");

    a_low_bits: assert property (@(posedge clk)
        disable iff (!resetn)
        (conv_done && $past(res_sel) == 2'h0)
        |-> temperature_result[2:0] == 3'h0)
        else $error("undefined bits not cleared at 9-bit");

    a_full_bits: assert property (@(posedge clk)
        disable iff (!resetn)
        (conv_done && $past(res_sel) == tcr_pkg::RES_12BIT)
        |-> temperature_result[3:0] == $past(sensor_code[3:0]))
        else $error("fraction bits lost at 12-bit");

    ////////////////////////////////////////////////////////////////////
    // checks: read-slot answer
    a_slot_busy: assert property (@(posedge clk)
        disable iff (!resetn)
        (slot_read && ext_powered && conv_busy) |=> dq_oe)
        else $error("busy slot not answered with zero");

    a_slot_done: assert property (@(posedge clk)
        disable iff (!resetn) (slot_read && !conv_busy) |=> !dq_oe)
        else $error("done slot answered with zero");

    a_parasite_quiet: assert property (@(posedge clk)
        disable iff (!resetn) (!ext_powered && slot_read) |=> !dq_oe)
        else $error("parasite device pulled the line");

    a_slot_release: assert property (@(posedge clk)
        disable iff (!resetn) (slot_end && !slot_read) |=> !dq_oe)
        else $error("line still pulled after the slot ended");

    a_pull_cause: assert property (@(posedge clk)
        disable iff (!resetn) $rose(dq_oe) |-> $past(slot_read))
        else $error("line pulled without a read slot");

    ////////////////////////////////////////////////////////////////////
    // checks: scratchpad, nonvolatile copy and power-up
    a_limit_write: assert property (@(posedge clk)
        disable iff (!resetn)
        (scratch_wr && !nv_recall && scratch_idx == tcr_pkg::IDX_LIMIT_HI)
        |=> limit_hi == $past(scratch_wdata))
        else $error("upper limit write did not land");

    a_config_write: assert property (@(posedge clk)
        disable iff (!resetn)
        (scratch_wr && !nv_recall && scratch_idx == tcr_pkg::IDX_CONFIG)
        |=> config_byte == $past(scratch_wdata))
        else $error("configuration write did not land");

    a_index_ignored: assert property (@(posedge clk)
        disable iff (!resetn)
        (scratch_wr && !nv_recall && scratch_idx == 2'h3)
        |=> $stable({limit_hi, limit_lo, config_byte}))
        else $error("unused scratch index changed a byte");

    a_recall_loads: assert property (@(posedge clk)
        disable iff (!resetn)
        nv_recall |=> ({limit_hi, limit_lo, config_byte}
                       == $past({nv_hi_r, nv_lo_r, nv_cfg_r})))
        else $error("recall did not restore the stored bytes");

    a_store_copies: assert property (@(posedge clk)
        disable iff (!resetn)
        nv_store |=> ({nv_hi_r, nv_lo_r, nv_cfg_r}
                      == $past({limit_hi, limit_lo, config_byte})))
        else $error("store did not copy the scratchpad bytes");

    a_reset_res: assert property (@(posedge clk)
        disable iff (!resetn)
        $rose(resetn) |-> res_sel == tcr_pkg::RES_12BIT)
        else $error("power-up resolution not 12 bits");

    a_reset_result: assert property (@(posedge clk)
        disable iff (!resetn)
        $rose(resetn) |-> (temperature_result == tcr_pkg::RESULT_RESET
                           && !conv_busy))
        else $error("power-up result not plus 85");
endmodule

// ---- design/tcr_pkg.sv ----
// constants shared by the temperature conversion readout block
package tcr_pkg;
    localparam logic [7:0]  CMD_CONVERT    = 8'h44;
    localparam logic [15:0] RESULT_RESET   = 16'h0550;
    localparam logic [7:0]  CFG_RESET      = 8'h7F;
    localparam logic [7:0]  LIMIT_HI_RESET = 8'h00;
    localparam logic [7:0]  LIMIT_LO_RESET = 8'h00;
    localparam int          CFG_RES_LSB    = 5;
    localparam int          CFG_RES_W      = 2;
    localparam logic [1:0]  IDX_LIMIT_HI   = 2'h0;
    localparam logic [1:0]  IDX_LIMIT_LO   = 2'h1;
    localparam logic [1:0]  IDX_CONFIG     = 2'h2;
    localparam logic [1:0]  RES_12BIT      = 2'h3;
    localparam int          SIGN_COPIES    = 4;
    localparam int          CNT_W          = 24;
    localparam int          CONV_CYCLES_12 = 1000;

    typedef enum logic [0:0] {
        TCR_IDLE,
        TCR_CONV
    } tcr_state_type;
endpackage

// ---- design/tcr_fmt_if.sv ----
// carries a raw sample and resolution to the formatter and back
`timescale 1ns/1ps
interface tcr_fmt_if;
    logic [11:0] sample;
    logic [1:0]  res;
    logic [15:0] result;

    modport ctrl (output sample, output res, input result);
    modport fmt  (input sample, input res, output result);
endinterface

// ---- design/tcr_format.sv ----
// formats a raw sensor sample into the 16-bit temperature result
`timescale 1ns/1ps
module tcr_format (
    tcr_fmt_if.fmt f
);
    logic [3:0]  low_mask;
    logic [15:0] extended;

    // finer bits below the chosen resolution are forced to zero
    assign low_mask = 4'hF << (3'd3 - {1'b0, f.res});
    // sign copies in 15..11, integer 10..4, fraction 3..0
    assign extended = {{tcr_pkg::SIGN_COPIES{f.sample[11]}},
                       f.sample};
    assign f.result = {extended[15:4], extended[3:0] & low_mask};
endmodule

// ---- sim/tcr_master_model.sv ----
// bus master model: commands, read slots, scratch bytes
`timescale 1ns/1ps
module tcr_master_model (
    input  wire logic clk,
    input  wire logic dq_oe,
    output logic      cmd_valid,
    output logic [7:0] cmd_byte,
    output logic      slot_read,
    output logic      slot_end,
    output logic      dq_in,
    output logic      scratch_wr,
    output logic [1:0] scratch_idx,
    output logic [7:0] scratch_wdata,
    output logic      nv_store,
    output logic      nv_recall
);
    // weak pullup holds the line high unless the device pulls it
    assign dq_in = ~dq_oe;
    initial begin
        {cmd_valid, slot_read, slot_end, scratch_wr} = 4'h0;
        {nv_store, nv_recall, scratch_idx} = 4'h0;
        cmd_byte = 8'h00;
        scratch_wdata = 8'h00;
    end
    ////////////////////////////////////////
    // one command byte; the device takes it at the second edge
    task automatic send_cmd(input logic [7:0] b);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_byte <= b;
        @(posedge clk);
        cmd_valid <= 1'b0;
    endtask
    // polling only makes sense with external power
    task automatic read_slot(output logic v);
        @(posedge clk);
        slot_read <= 1'b1;
        @(posedge clk);
        slot_read <= 1'b0;
        #1 v = dq_in;
        @(posedge clk);
        slot_end <= 1'b1;
        @(posedge clk);
        slot_end <= 1'b0;
    endtask
    // single scratchpad byte write
    task automatic put_byte(input logic [1:0] i, input logic [7:0] d);
        @(posedge clk);
        scratch_wr <= 1'b1;
        scratch_idx <= i;
        scratch_wdata <= d;
        @(posedge clk);
        scratch_wr <= 1'b0;
    endtask
    // store or recall of the nonvolatile copy
    task automatic nv_pulse(input logic recall);
        @(posedge clk);
        nv_store <= ~recall;
        nv_recall <= recall;
        @(posedge clk);
        {nv_store, nv_recall} <= 2'h0;
    endtask
endmodule

// ---- sim/tcr_top_test.sv ----
// self-checking bench for the conversion readout block
`timescale 1ns/1ps
module tcr_top_test;
    localparam int N = 16;
    logic clk, resetn, ext_powered, cmd_valid, slot_read, slot_end;
    logic dq_in, scratch_wr, nv_store, nv_recall, dq_out, dq_oe;
    logic conv_busy, conv_done, v;
    logic [11:0] sensor_code;
    logic [7:0] cmd_byte, scratch_wdata, limit_hi, limit_lo, config_byte;
    logic [1:0] scratch_idx;
    logic [15:0] temperature_result;
    int miscompares = 0;
    int cmp_count = 0;
    int n;
    tcr_top #(.CONV_CYCLES(N)) i_tcr_top (.clk(clk), .resetn(resetn),
        .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .slot_read(slot_read),
        .ext_powered(ext_powered), .sensor_code(sensor_code),
        .slot_end(slot_end), .dq_in(dq_in), .scratch_wr(scratch_wr),
        .scratch_idx(scratch_idx), .scratch_wdata(scratch_wdata),
        .nv_store(nv_store), .nv_recall(nv_recall), .dq_out(dq_out),
        .dq_oe(dq_oe), .temperature_result(temperature_result),
        .limit_hi(limit_hi), .limit_lo(limit_lo),
        .config_byte(config_byte), .conv_busy(conv_busy),
        .conv_done(conv_done));
    tcr_master_model i_tcr_master_model (.clk(clk), .dq_oe(dq_oe),
        .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .slot_read(slot_read),
        .slot_end(slot_end), .dq_in(dq_in), .scratch_wr(scratch_wr),
        .scratch_idx(scratch_idx), .scratch_wdata(scratch_wdata),
        .nv_store(nv_store), .nv_recall(nv_recall));
    ////////////////////////////////////////
    // comparisons and the closing report
    task automatic chk_val(input string w, input logic [15:0] e, g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic chk_bit(input string w, input logic e, g);
        chk_val(w, {15'h0000, e}, {15'h0000, g});
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // bounded count of busy cycles after the taking edge
    task automatic count_busy(output int c);
        c = 0;
        #1;
        while (conv_busy === 1'b1 && c < 1000) begin
            c++;
            @(posedge clk);
            #1;
        end
        if (c >= 1000) begin
            miscompares++;
            conclude();
        end
    endtask
    // full conversion: length, done pulse and stored value
    task automatic conv(input logic [11:0] s, input int r,
                        input logic [15:0] e);
        @(posedge clk);
        sensor_code <= s;
        i_tcr_master_model.send_cmd(8'h44);
        count_busy(n);
        chk_val("busy cycles", 16'(N >> (3 - r)), 16'(n));
        chk_bit("done", 1'b1, conv_done);
        chk_val("result", e, temperature_result);
        @(posedge clk);
        #1 chk_bit("done end", 1'b0, conv_done);
    endtask
    ////////////////////////////////////////
    task automatic test_reset;
        chk_val("reset result", 16'h0550, temperature_result);
        chk_val("reset config", 16'h007F, {8'h00, config_byte});
        chk_bit("reset busy", 1'b0, conv_busy);
        chk_val("reset limits", 16'h0000, {limit_hi, limit_lo});
        $display("test reset done");
    endtask
    // signs both ways, then polling during and after a conversion
    task automatic test_powered;
        conv(12'h191, 3, 16'h0191);
        conv(12'hF5E, 3, 16'hFF5E);
        i_tcr_master_model.send_cmd(8'h44);
        i_tcr_master_model.read_slot(v);
        chk_bit("slot busy", 1'b0, v);
        count_busy(n);
        i_tcr_master_model.read_slot(v);
        chk_bit("slot done", 1'b1, v);
        #1 chk_bit("line free", 1'b0, dq_oe);
        chk_bit("drive level", 1'b0, dq_out);
        $display("test powered done");
    endtask
    // low bits cleared at each shorter resolution
    task automatic test_res;
        for (int r = 0; r < 4; r++) begin
            i_tcr_master_model.put_byte(2'h2, 8'(8'h1F | (r << 5)));
            conv(12'hF5F, r, 16'hFF5F & (16'hFFFF << (3 - r)));
        end
        $display("test resolution done");
    endtask
    // foreign code and a repeat while busy must not restart
    task automatic test_refuse;
        i_tcr_master_model.send_cmd(8'h45);
        #1 chk_bit("foreign code", 1'b0, conv_busy);
        i_tcr_master_model.send_cmd(8'h44);
        i_tcr_master_model.send_cmd(8'h44);
        count_busy(n);
        chk_val("no restart", 16'(N - 2), 16'(n));
        $display("test refuse done");
    endtask
    // parasite power: strong pullup, no traffic until the conversion
    // is over; a slot after that must find the line released
    task automatic test_parasite;
        @(posedge clk);
        ext_powered <= 1'b0;
        i_tcr_master_model.send_cmd(8'h44);
        v = 1'b0;
        for (int k = 0; k < N; k++) begin
            @(posedge clk);
            #1 v = v | dq_oe;
        end
        chk_bit("parasite pull", 1'b0, v);
        chk_bit("parasite idle", 1'b0, conv_busy);
        chk_bit("parasite done", 1'b1, conv_done);
        i_tcr_master_model.read_slot(v);
        chk_bit("parasite slot", 1'b1, v);
        $display("test parasite done");
    endtask
    // power lost after a config write: volatile bytes reset, stored copy survives
    task automatic test_power_loss;
        i_tcr_master_model.put_byte(2'h2, 8'h1F);
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        #1 test_reset();
        i_tcr_master_model.nv_pulse(1'b1);
        #1 chk_val("kept limits", 16'h4BF6, {limit_hi, limit_lo});
        $display("test power loss done");
    endtask
    // limits, ignored index, nonvolatile store and recall
    task automatic test_scratch;
        i_tcr_master_model.put_byte(2'h0, 8'h4B);
        i_tcr_master_model.put_byte(2'h1, 8'hF6);
        i_tcr_master_model.put_byte(2'h3, 8'hAA);
        #1 chk_val("limits", 16'h4BF6, {limit_hi, limit_lo});
        chk_val("config", 16'h007F, {8'h00, config_byte});
        i_tcr_master_model.nv_pulse(1'b0);
        i_tcr_master_model.put_byte(2'h0, 8'h00);
        i_tcr_master_model.nv_pulse(1'b1);
        #1 chk_val("recall", 16'h4BF6, {limit_hi, limit_lo});
        $display("test scratch done");
    endtask
    ////////////////////////////////////////
    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // reset for 8 cycles, then the scenarios
    initial begin
        resetn = 1'b0;
        ext_powered = 1'b1;
        sensor_code = 12'h000;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        #1 test_reset();
        test_powered();
        test_res();
        test_refuse();
        test_scratch();
        test_power_loss();
        test_parasite();
        conclude();
    end
endmodule
